// File: cftr_pkg.sv
// Purpose: Shared constants for the transceiver control and fault report logic
// Assumes: 200 MHz clock, one clock domain
// Notes: Bus levels are abstracted to digital dominant/recessive indications
package cftr_pkg;
	localparam int CLK_MHZ = 200;
	// Dominant limit time in microseconds, converted to cycles below
	localparam int DOM_LIMIT_US = 2000;
	localparam int DOM_LIMIT_CYC = DOM_LIMIT_US * CLK_MHZ;
	localparam int ENABLE_EDGES = 100;
	localparam int REPORT_EDGES = 16;
	localparam int CLEAR_EDGES = 10;
	localparam int TXFAIL_PULSES = 10;
	localparam int CODE_BITS = 6;
	localparam logic [5:0] CODE_OVERCURRENT = 6'h2A;
	localparam logic [5:0] CODE_OVERVOLTAGE = 6'h2C;
	localparam logic [5:0] CODE_TXFAIL = 6'h32;
	localparam logic [5:0] CODE_NONE = 6'h00;
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_WIDTH = 1;
	typedef enum logic [1:0] {
		CFTR_ARMING,
		CFTR_WATCH,
		CFTR_REPORT,
		CFTR_CLEAR
	} cftr_phase_type;
endpackage

// File: cftr_fifo.sv
// Purpose: Parameterised FIFO with valid/ready on both sides
// Assumes: Single clock, depth is a power of two
// Notes: Full and empty come from pointers with an extra wrap bit
`timescale 1ns/1ps
module cftr_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 32
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} cftr_fifo_st_type;
	cftr_fifo_st_type s_q;
	cftr_fifo_st_type s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// Honest flags: full when pointers differ only in wrap bit
	assign in_ready = !((s_q.wr[AW] != s_q.rd[AW]) && (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]));
	assign out_valid = (s_q.wr != s_q.rd);
	assign out_data = mem[s_q.rd[AW-1:0]];
	assign push = ce && in_valid && in_ready;
	assign pop = ce && out_valid && out_ready;

	// Pointer update
	always_comb
	begin
		s_d = s_q;
		if (push)
		begin
			s_d.wr = s_q.wr + 1'b1;
		end
		if (pop)
		begin
			s_d.rd = s_q.rd + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// Storage has no reset, it is only read behind valid
	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[s_q.wr[AW-1:0]] <= in_data;
		end
	end
endmodule

// File: cftr_core.sv
// Purpose: Transmit/receive path, dominant timeout and fault report sequencer
// Assumes: Pins come from outside and are synchronised; analog faults arrive as levels
// Notes: Received bus levels pass a FIFO on the way to the receive output
// Functional notes
// - Short transmit low drives dominant and receive low; high gives recessive.
// - Transmit low beyond the limit disables the driver, bus recessive, receive high.
// - After timeout, driver stays off until a transmit rising edge.
// - Receive low for dominant differential, high for recessive differential.
// - Shorted or undriven terminated bus gives high receive output.
// - Thermal shutdown floats drivers; normal operation resumes when it clears.
// - Fault detection runs only in normal mode, not standby or silent.
// - Detection enables after 100 transmit rising edges from power-up.
// - Sixteen rising edges after a fault shift the stored code out.
// - Ten more pulses after the report clear the fault.
// - Driver overcurrent while enabled records code 101010.
// - Overvoltage on either line while enabled records code 101100.
// - Receive not following transmit for 10 pulses records code 110010.
// - Any fault raises the fault flag and offers the code on receive.
// - Fault flag low without fault, high on any detected fault.
// - Fault floats the bus and latches only the first code.
// - Clearing disables detection; another 100 rising edges re-enable it.
// - During a fault both bus lines are held in high impedance.
`timescale 1ns/1ps
module cftr_core #(
	parameter int DOM_LIMIT_CYC = cftr_pkg::DOM_LIMIT_CYC,
	parameter int FIFO_DEPTH = cftr_pkg::FIFO_DEPTH
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic tx_pin,
	input wire logic low_power_select,
	input wire logic silent_select,
	input wire logic bus_dominant,
	input wire logic overcurrent,
	input wire logic overvoltage,
	input wire logic thermal_shutdown,
	output logic rx_pin,
	output logic fault_flag,
	output logic canh_out,
	output logic canh_oe,
	output logic canl_out,
	output logic canl_oe
);
	localparam int TW = $clog2(DOM_LIMIT_CYC + 1);

	typedef struct packed {
		logic [1:0] tx_sync;
		logic [1:0] low_power_select_sync;
		logic [1:0] sil_sync;
		logic [1:0] bus_sync;
		logic [1:0] oc_sync;
		logic [1:0] ov_sync;
		logic [1:0] th_sync;
		logic tx_prev;
		logic [TW-1:0] dom_timer;
		logic timed_out;
		cftr_pkg::cftr_phase_type phase;
		logic [6:0] edge_cnt;
		logic [3:0] mismatch_cnt;
		logic pulse_mismatch;
		logic [5:0] code;
		logic fault;
		logic rx_out;
		logic canh_drv;
		logic canh_en;
		logic canl_drv;
		logic canl_en;
	} cftr_state_type;

	cftr_state_type s_q;
	cftr_state_type s_d;
	logic tx_s;
	logic tx_rise;
	logic tx_fall;
	logic normal_mode;
	logic drive_dom;
	logic fifo_in_ready;
	logic fifo_out_data;
	logic fifo_out_valid;
	logic rx_bus_level;

	// Count saturating at the limit: compare against the parameter, not the package
	function automatic logic timer_expired(input logic [TW-1:0] t);
		timer_expired = (t >= TW'(DOM_LIMIT_CYC));
	endfunction

	assign tx_s = s_q.tx_sync[1];
	assign tx_rise = tx_s && !s_q.tx_prev;
	assign tx_fall = !tx_s && s_q.tx_prev;
	assign normal_mode = !s_q.low_power_select_sync[1] && !s_q.sil_sync[1];
	// Driver active only in normal mode, no timeout, no fault, no thermal stop
	assign drive_dom = !tx_s && normal_mode && !s_q.timed_out && !s_q.fault
		&& !s_q.th_sync[1];

	// Bus level FIFO keeps receive samples in order; it drains every cycle
	cftr_fifo #(
		.WIDTH(cftr_pkg::FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.in_data(!s_q.bus_sync[1]),
		.in_valid(1'b1),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(1'b1)
	);
	// Empty FIFO reads as recessive, so an idle bus shows high
	assign rx_bus_level = fifo_out_valid ? fifo_out_data : 1'b1;

	always_comb
	begin
		s_d = s_q;
		s_d.tx_sync = {s_q.tx_sync[0], tx_pin};
		s_d.low_power_select_sync = {s_q.low_power_select_sync[0], low_power_select};
		s_d.sil_sync = {s_q.sil_sync[0], silent_select};
		s_d.bus_sync = {s_q.bus_sync[0], bus_dominant};
		s_d.oc_sync = {s_q.oc_sync[0], overcurrent};
		s_d.ov_sync = {s_q.ov_sync[0], overvoltage};
		s_d.th_sync = {s_q.th_sync[0], thermal_shutdown};
		s_d.tx_prev = tx_s;
		// Dominant timer runs while transmit is low, cleared by a rising edge
		if (tx_s)
		begin
			s_d.dom_timer = '0;
		end
		else if (!timer_expired(s_q.dom_timer))
		begin
			s_d.dom_timer = s_q.dom_timer + 1'b1;
		end
		if (!tx_s && timer_expired(s_q.dom_timer))
		begin
			s_d.timed_out = 1'b1;
		end
		else if (tx_rise)
		begin
			s_d.timed_out = 1'b0;
		end
		// Arm the check at each falling edge, clear it on any dominant receive in the
		// low half; a sample taken only at the falling edge would see stale recessive
		// behind the receive latency. Low halves shorter than that latency always fail.
		if (tx_fall)
		begin
			s_d.pulse_mismatch = 1'b1;
		end
		else if (!tx_s && !rx_bus_level)
		begin
			s_d.pulse_mismatch = 1'b0;
		end
		// Fault sequencer stepped by transmit rising edges; line faults end the watch in any cycle
		case (s_q.phase)
			cftr_pkg::CFTR_ARMING:
			begin
				s_d.mismatch_cnt = '0;
				if (tx_rise && normal_mode)
				begin
					if (s_q.edge_cnt == 7'(cftr_pkg::ENABLE_EDGES - 1))
					begin
						s_d.edge_cnt = '0;
						s_d.phase = cftr_pkg::CFTR_WATCH;
					end
					else
					begin
						s_d.edge_cnt = s_q.edge_cnt + 1'b1;
					end
				end
			end
			cftr_pkg::CFTR_WATCH:
			begin
				if (!normal_mode)
				begin
					s_d.mismatch_cnt = '0;
				end
				else if (s_q.oc_sync[1])
				begin
					s_d.code = cftr_pkg::CODE_OVERCURRENT;
					s_d.fault = 1'b1;
					s_d.phase = cftr_pkg::CFTR_REPORT;
				end
				else if (s_q.ov_sync[1])
				begin
					s_d.code = cftr_pkg::CODE_OVERVOLTAGE;
					s_d.fault = 1'b1;
					s_d.phase = cftr_pkg::CFTR_REPORT;
				end
				else if (tx_rise)
				begin
					// A pulse whose low half never showed dominant counts as failed
					if (s_q.pulse_mismatch)
					begin
						if (s_q.mismatch_cnt == 4'(cftr_pkg::TXFAIL_PULSES - 1))
						begin
							s_d.code = cftr_pkg::CODE_TXFAIL;
							s_d.fault = 1'b1;
							s_d.phase = cftr_pkg::CFTR_REPORT;
						end
						else
						begin
							s_d.mismatch_cnt = s_q.mismatch_cnt + 1'b1;
						end
					end
					else
					begin
						s_d.mismatch_cnt = '0;
					end
				end
			end
			cftr_pkg::CFTR_REPORT:
			begin
				// Later faults are not looked at here, so the first code stays
				if (tx_rise)
				begin
					if (s_q.edge_cnt == 7'(cftr_pkg::REPORT_EDGES - 1))
					begin
						s_d.edge_cnt = '0;
						s_d.phase = cftr_pkg::CFTR_CLEAR;
					end
					else
					begin
						s_d.edge_cnt = s_q.edge_cnt + 1'b1;
					end
				end
			end
			cftr_pkg::CFTR_CLEAR:
			begin
				if (tx_rise)
				begin
					if (s_q.edge_cnt == 7'(cftr_pkg::CLEAR_EDGES - 1))
					begin
						s_d.edge_cnt = '0;
						s_d.fault = 1'b0;
						s_d.code = cftr_pkg::CODE_NONE;
						s_d.phase = cftr_pkg::CFTR_ARMING;
					end
					else
					begin
						s_d.edge_cnt = s_q.edge_cnt + 1'b1;
					end
				end
			end
			default:
			begin
				s_d.phase = cftr_pkg::CFTR_ARMING;
			end
		endcase
		// Receive output: code bits MSB first during report, high while the fault is held, else bus level
		if (s_q.phase == cftr_pkg::CFTR_REPORT)
		begin
			if (tx_rise && s_q.edge_cnt < 7'(cftr_pkg::CODE_BITS))
			begin
				s_d.rx_out = s_q.code[3'(cftr_pkg::CODE_BITS - 1) - s_q.edge_cnt[2:0]];
			end
			else if (tx_rise)
			begin
				s_d.rx_out = 1'b1;
			end
		end
		else if (s_q.fault)
		begin
			s_d.rx_out = 1'b1;
		end
		else
		begin
			s_d.rx_out = rx_bus_level;
		end
		// Bus drivers: enable only for dominant; recessive and fault float the lines
		s_d.canh_drv = drive_dom;
		s_d.canl_drv = 1'b0;
		s_d.canh_en = drive_dom;
		s_d.canl_en = drive_dom;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_q <= '0;
			s_q.tx_sync <= 2'h3;
			s_q.tx_prev <= 1'b1;
			s_q.rx_out <= 1'b1;
			s_q.pulse_mismatch <= 1'b1;
			s_q.phase <= cftr_pkg::CFTR_ARMING;
		end
		else if (ce)
		begin
			s_q <= s_d;
		end
	end

	assign rx_pin = s_q.rx_out;
	assign fault_flag = s_q.fault;
	assign canh_out = s_q.canh_drv;
	assign canh_oe = s_q.canh_en;
	assign canl_out = s_q.canl_drv;
	assign canl_oe = s_q.canl_en;

	// Fault raises the flag within one cycle of a synchronised overcurrent
	AST_OC_FLAG: assert property (@(posedge clk) disable iff (rst)
		(ce && s_q.phase == cftr_pkg::CFTR_WATCH && normal_mode && s_q.oc_sync[1])
		|=> (fault_flag && s_q.code == cftr_pkg::CODE_OVERCURRENT))
		else $error("overcurrent not recorded");
	AST_OV_CODE: assert property (@(posedge clk) disable iff (rst)
		(ce && s_q.phase == cftr_pkg::CFTR_WATCH && normal_mode && !s_q.oc_sync[1]
		&& s_q.ov_sync[1]) |=> (s_q.code == cftr_pkg::CODE_OVERVOLTAGE))
		else $error("overvoltage not recorded");
	AST_FAULT_FLOAT: assert property (@(posedge clk) disable iff (rst)
		(ce && s_q.fault) |=> (!canh_oe && !canl_oe))
		else $error("bus driven during fault");
	AST_FIRST_CODE: assert property (@(posedge clk) disable iff (rst)
		(s_q.fault && $past(s_q.fault)) |-> $stable(s_q.code))
		else $error("fault code replaced");
	AST_LOW_POWER_SELECT_NO_DETECT: assert property (@(posedge clk) disable iff (rst)
		(!normal_mode && !s_q.fault) |=> !s_q.fault)
		else $error("fault detected outside normal mode");
	AST_TIMEOUT_OFF: assert property (@(posedge clk) disable iff (rst)
		(ce && s_q.timed_out) |=> !canh_oe)
		else $error("driver on after dominant timeout");
	AST_THERMAL: assert property (@(posedge clk) disable iff (rst)
		(ce && s_q.th_sync[1]) |=> !canh_oe)
		else $error("driver on in thermal shutdown");
	AST_FLAG_IDLE: assert property (@(posedge clk) disable iff (rst)
		(s_q.phase == cftr_pkg::CFTR_ARMING) |-> !fault_flag)
		else $error("fault flag high while arming");
	AST_DOM_DRIVE: assert property (@(posedge clk) disable iff (rst)
		(ce && drive_dom) |=> (canh_oe && canh_out && canl_oe && !canl_out))
		else $error("dominant not driven");
	// Failure fault lands on the tenth unfollowed pulse unless a line fault wins
	sequence txfail_tenth;
		ce && s_q.phase == cftr_pkg::CFTR_WATCH && normal_mode && !s_q.oc_sync[1]
			&& !s_q.ov_sync[1] && tx_rise && s_q.pulse_mismatch
			&& s_q.mismatch_cnt == 4'(cftr_pkg::TXFAIL_PULSES - 1);
	endsequence
	AST_TXFAIL_CODE: assert property (@(posedge clk) disable iff (rst)
		txfail_tenth |=> (fault_flag && s_q.code == cftr_pkg::CODE_TXFAIL))
		else $error("transmission failure not recorded");
	// Past the six code bits the receive output idles high for the rest of the report
	sequence report_tail;
		ce && s_q.phase == cftr_pkg::CFTR_REPORT && tx_rise
			&& s_q.edge_cnt >= 7'(cftr_pkg::CODE_BITS);
	endsequence
	AST_REPORT_TAIL: assert property (@(posedge clk) disable iff (rst)
		report_tail |=> rx_pin)
		else $error("receive not high after fault code");
	AST_TIMEOUT_RELEASE: assert property (@(posedge clk) disable iff (rst)
		(ce && s_q.timed_out && tx_rise) |=> !s_q.timed_out)
		else $error("driver not released by rising edge");
endmodule

// File: cftr_ctrl_model.sv
// Purpose: Behavioural protocol controller facing the transceiver pins
// Assumes: Transmit line idles high through its pull-up
// Notes: Captures receive once per pulse, a little after each rising edge
`timescale 1ns/1ps
module cftr_ctrl_model (
	input wire logic clk,
	input wire logic rx_pin,
	input wire logic drv_on,
	output logic tx_pin
);
	logic [15:0] cap_q;
	logic drv_q;
	// Idle recessive from time zero
	initial
	begin
		tx_pin = 1'b1;
		cap_q = 16'h0000;
		drv_q = 1'b0;
	end
	// Remember any driver enable seen while the line is held low
	always @(posedge clk)
		if (!tx_pin && drv_on)
			drv_q <= 1'b1;
	task automatic clr();
		drv_q = 1'b0;
	endtask
	// Pins change just after the edge so sampling never races
	task automatic set_tx(input logic v);
		@(posedge clk);
		#1;
		tx_pin = v;
	endtask
	// One low-high pulse; high must be at least 7 cycles
	task automatic pulse(input int lo, input int hi);
		set_tx(1'b0);
		repeat (lo - 1) @(posedge clk);
		set_tx(1'b1);
		repeat (6) @(posedge clk);
		#1;
		cap_q = {cap_q[14:0], rx_pin};
		repeat (hi - 7) @(posedge clk);
	endtask
endmodule

// File: can_transceiver_fault_report_test.sv
// Purpose: Self-checking bench for the transceiver control and fault report
// Assumes: Short dominant limit for run time; bus modelled from driver enables
// Notes: Pulse widths are random but long enough for the receive path latency
`timescale 1ns/1ps
module can_transceiver_fault_report_test;
	localparam int DOM_CYC = 50;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic low_power_select = 1'b0;
	logic silent_select = 1'b0;
	logic overcurrent = 1'b0;
	logic overvoltage = 1'b0;
	logic thermal_shutdown = 1'b0;
	logic bus_open = 1'b0;
	logic ext_dom = 1'b0;
	logic bus_dominant;
	logic tx_pin, rx_pin, fault_flag, canh_out, canh_oe, canl_out, canl_oe;
	logic [31:0] seed = 32'h3B1CA878;
	int num_errors = 0;
	int n_tests = 0;
	always #2.5 clk = ~clk;
	// Bus goes dominant when both lines drive or another node drives; open load kills the local drive only
	assign bus_dominant = ext_dom | (canh_oe & canl_oe & canh_out & ~canl_out & ~bus_open);
	cftr_core #(.DOM_LIMIT_CYC(DOM_CYC)) u_dut (
		.clk(clk), .rst(rst), .ce(ce), .tx_pin(tx_pin),
		.low_power_select(low_power_select), .silent_select(silent_select),
		.bus_dominant(bus_dominant), .overcurrent(overcurrent), .overvoltage(overvoltage),
		.thermal_shutdown(thermal_shutdown), .rx_pin(rx_pin), .fault_flag(fault_flag),
		.canh_out(canh_out), .canh_oe(canh_oe), .canl_out(canl_out), .canl_oe(canl_oe));
	cftr_ctrl_model u_ctrl (.clk(clk), .rx_pin(rx_pin), .drv_on(canh_oe | canl_oe),
		.tx_pin(tx_pin));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Random widths; low stays far below the dominant limit
	task automatic pulses(input int n);
		int lo;
		for (int i = 0; i < n; i++)
		begin
			seed = xs(seed);
			lo = 16 + seed[2:0];
			u_ctrl.pulse(lo, 12 + seed[5:3]);
		end
	endtask
	task automatic inject(input int k);
		if (k == 0)
			overcurrent = 1'b1;
		else
			overvoltage = 1'b1;
		cyc(8);
		overcurrent = 1'b0;
		overvoltage = 1'b0;
		cyc(4);
	endtask
	task automatic flag(input logic exp);
		chk("fault flag", {15'h0000, exp}, {15'h0000, fault_flag});
	endtask
	task automatic idle_pins();
		chk("idle pins", 16'h0002, {12'h000, canh_oe, canl_oe, rx_pin, fault_flag});
	endtask
	task automatic drive(input logic exp);
		chk("bus drive", {12'h000, exp, exp, exp, 1'b0},
			{12'h000, canh_oe, canh_out, canl_oe, canl_out});
	endtask
	// Code leaves first, then receive idles high until the clear pulses
	task automatic report(input logic [5:0] code);
		u_ctrl.clr();
		pulses(16);
		chk("fault code", {code, 10'h3FF}, u_ctrl.cap_q);
		chk("drive in fault", 16'h0000, {15'h0000, u_ctrl.drv_q});
		pulses(9);
		cyc(6);
		flag(1'b1);
		pulses(1);
		cyc(6);
		flag(1'b0);
	endtask
	// Watchdog sized well past the expected run
	initial
	begin
		#200us;
		num_errors++;
		test_done();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		#1;
		idle_pins();
		rst = 1'b0;
		cyc(3);
		pulses(99);
		inject(0);
		flag(1'b0);
		pulses(1);
		low_power_select = 1'b1;
		cyc(4);
		inject(0);
		flag(1'b0);
		low_power_select = 1'b0;
		silent_select = 1'b1;
		cyc(4);
		inject(1);
		flag(1'b0);
		silent_select = 1'b0;
		cyc(4);
		inject(0);
		flag(1'b1);
		inject(1);
		report(cftr_pkg::CODE_OVERCURRENT);
		inject(1);
		flag(1'b0);
		pulses(100);
		inject(1);
		flag(1'b1);
		report(cftr_pkg::CODE_OVERVOLTAGE);
		pulses(100);
		// A bus that follows transmit must not build up a failure count
		pulses(12);
		cyc(6);
		flag(1'b0);
		bus_open = 1'b1;
		pulses(10);
		cyc(6);
		flag(1'b1);
		bus_open = 1'b0;
		report(cftr_pkg::CODE_TXFAIL);
		// Reset in mid-run, then the plain transmit and receive paths
		rst = 1'b1;
		cyc(2);
		idle_pins();
		rst = 1'b0;
		cyc(3);
		u_ctrl.set_tx(1'b0);
		cyc(12);
		drive(1'b1);
		chk("rx dominant", 16'h0000, {15'h0000, rx_pin});
		cyc(DOM_CYC);
		drive(1'b0);
		chk("rx after timeout", 16'h0001, {15'h0000, rx_pin});
		cyc(20);
		drive(1'b0);
		u_ctrl.set_tx(1'b1);
		cyc(8);
		u_ctrl.set_tx(1'b0);
		cyc(8);
		drive(1'b1);
		u_ctrl.set_tx(1'b1);
		cyc(10);
		chk("recessive", 16'h0001, {14'h0000, canh_oe | canl_oe, rx_pin});
		thermal_shutdown = 1'b1;
		u_ctrl.set_tx(1'b0);
		cyc(8);
		drive(1'b0);
		thermal_shutdown = 1'b0;
		cyc(8);
		drive(1'b1);
		u_ctrl.set_tx(1'b1);
		ext_dom = 1'b1;
		cyc(10);
		chk("rx other node", 16'h0000, {15'h0000, rx_pin});
		ext_dom = 1'b0;
		cyc(10);
		chk("rx undriven", 16'h0001, {15'h0000, rx_pin});
		// Clock enable low freezes the receive path until it returns
		ce = 1'b0;
		ext_dom = 1'b1;
		cyc(10);
		chk("rx frozen", 16'h0001, {15'h0000, rx_pin});
		ce = 1'b1;
		cyc(10);
		chk("rx after enable", 16'h0000, {15'h0000, rx_pin});
		ext_dom = 1'b0;
		test_done();
	end
endmodule
